// ===== iisf_regs.svh
// constants for the isolated input spi frame block
// assumes inclusion by the frame logic and its crc leaf
`ifndef IISF_REGS_SVH
`define IISF_REGS_SVH
`define IISF_CRC_POLY     5'h15
`define IISF_CRC_SEED     5'h07
`define IISF_PAYLOAD_BITS 5'h13
`define IISF_FRAME_CRC    5'h18
`define IISF_FRAME_PLAIN  5'h10
`define IISF_FLT1_CRC     3'h0
`define IISF_FLT1_POR     3'h1
`define IISF_FLT1_SUPLOW  3'h2
`define IISF_FLT1_SUPMIS  3'h3
`define IISF_FLT1_WBG     3'h4
`define IISF_FLT1_F2      3'h5
`define IISF_FLT1_RESET   8'h02
`define IISF_ADDR_FLT1    5'h04
`define IISF_ADDR_FLT2    5'h1C
`endif

// ===== iisf_pkg.sv
// types shared by the isolated input spi frame files
// assumes nothing of its surroundings
package iisf_pkg;
	typedef enum logic [1:0] {
		IISF_MODE0,
		IISF_MODE1,
		IISF_MODE2,
		IISF_MODE3
	} iisf_mode_t;
endpackage

// ===== iisf_crc5.sv
// serial 5-bit check value register, msb first
// assumes one bit per shift strobe on clk_in
`timescale 1ns/1ps
`include "iisf_regs.svh"
module iisf_crc5 (
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	// control
	input  wire logic       seed_in,
	input  wire logic       shift_in,
	input  wire logic       bit_in,
	// result
	output logic [4:0]      crc_out
);
	logic [4:0] crc_q;
	logic       fb;
	// the seed is the register's starting value, so no shift cycles are spent on it
	assign fb = crc_q[4] ^ bit_in;
	always_ff @(posedge clk_in) begin
		if (rst_in || seed_in) begin
			crc_q <= `IISF_CRC_SEED;
		end else if (shift_in) begin
			crc_q <= {crc_q[3:0], 1'b0} ^ ({5{fb}} & `IISF_CRC_POLY);
		end
	end
	assign crc_out = crc_q;
endmodule

// ===== iisf_frame.sv
// spi frame engine: strap modes, check bits, fault flags, capture latches
// assumes host pins arrive asynchronous; field status arrives on clk_in
`timescale 1ns/1ps
`include "iisf_regs.svh"
module iisf_frame (
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	// host spi pins
	input  wire logic       host_chip_select_n_in,
	input  wire logic       host_serial_clock_in,
	input  wire logic       host_serial_in_in,
	input  wire logic       shared_capture_n_in,
	output logic            host_serial_out_out,
	output logic            host_fault_out_n_out,
	// straps
	input  wire logic       mode_strap_high_in,
	input  wire logic       mode_strap_low_in,
	// field status
	input  wire logic [7:0] input_state_byte_in,
	input  wire logic [7:0] wire_break_status_in,
	input  wire logic       field_supply_low_in,
	input  wire logic       field_supply_missing_in,
	input  wire logic       wire_break_summary_in,
	input  wire logic       secondary_fault_in,
	input  wire logic       supply_loss_event_in,
	// configuration and indicators
	input  wire logic       check_error_alert_enable_in,
	input  wire logic       fault_latch_mode_in,
	input  wire logic [7:0] reg_read_data_in,
	output logic            field_ready_ind_out,
	output logic            field_fault_out_n_out,
	output logic [4:0]      reg_addr_out,
	output logic [7:0]      reg_write_data_out,
	output logic            reg_write_out,
	output logic            secondary_read_out,
	output logic            clock_count_error_out,
	output logic [7:0]      primary_fault_reg_out
);
	typedef enum logic [1:0] {
		IISF_IDLE,
		IISF_SHIFT,
		IISF_DONE
	} iisf_state_t;
	logic [2:0]         cs_s_q, sck_s_q, sdi_s_q, lat_s_q;
	logic               cs_n, sck, sdi, lat_n, sck_prev_q, cs_prev_q, lat_prev_q;
	logic               rise, fall, cs_fall, cs_rise, lat_fall;
	iisf_state_t        state_q;
	iisf_pkg::iisf_mode_t mode_q;
	logic               mode_ok_q;
	logic [23:0]        rx_q;
	logic [23:0]        tx_q;
	logic [5:0]         cnt_q;
	logic [7:0]         di_latch_q, wb_latch_q;
	logic [2:0]         sts_latch_q;
	logic               prev_read_q;
	logic [7:0]         read_hold_q;
	logic [7:0]         flt1_q;
	logic               crc_err_q, field_fault_out_n_n_q, host_fault_out_n_n_q, ready_q;
	logic               crc_seed, crc_shift, crc_bit, use_crc, frame_ok;
	logic [4:0]         crc_val;
	logic [4:0]         tx_crc_val;
	logic [7:0]         byte2;
	logic [2:0]         sts_now;
	// only the third stage is read, keeping the first two as a pure synchroniser
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cs_s_q  <= 3'h7;
			sck_s_q <= 3'h0;
			sdi_s_q <= 3'h0;
			lat_s_q <= 3'h7;
		end else begin
			cs_s_q  <= {cs_s_q[1:0], host_chip_select_n_in};
			sck_s_q <= {sck_s_q[1:0], host_serial_clock_in};
			sdi_s_q <= {sdi_s_q[1:0], host_serial_in_in};
			lat_s_q <= {lat_s_q[1:0], shared_capture_n_in};
		end
	end
	assign cs_n  = cs_s_q[2];
	assign sck   = sck_s_q[2];
	assign sdi   = sdi_s_q[2];
	assign lat_n = lat_s_q[2];
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			sck_prev_q <= 1'b0;
			cs_prev_q  <= 1'b1;
			lat_prev_q <= 1'b1;
		end else begin
			sck_prev_q <= sck;
			cs_prev_q  <= cs_n;
			lat_prev_q <= lat_n;
		end
	end
	// clock edges outside a frame are ignored
	assign rise     = sck & ~sck_prev_q & ~cs_n;
	assign fall     = ~sck & sck_prev_q & ~cs_n;
	assign cs_fall  = ~cs_n & cs_prev_q;
	assign cs_rise  = cs_n & ~cs_prev_q;
	assign lat_fall = ~lat_n & lat_prev_q;
	// strap caught once after reset release
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			mode_q    <= iisf_pkg::IISF_MODE0;
			mode_ok_q <= 1'b0;
		end else if (!mode_ok_q) begin
			mode_q    <= iisf_pkg::iisf_mode_t'({mode_strap_high_in, mode_strap_low_in});
			mode_ok_q <= 1'b1;
		end
	end
	assign use_crc = (mode_q == iisf_pkg::IISF_MODE0) || (mode_q == iisf_pkg::IISF_MODE2);
	// status bits that freeze on select only
	assign sts_now = {wire_break_summary_in, field_supply_missing_in, field_supply_low_in};
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			di_latch_q  <= 8'h00;
			wb_latch_q  <= 8'h00;
			sts_latch_q <= 3'h0;
		end else if (cs_fall || (lat_fall && cs_n)) begin
			di_latch_q <= input_state_byte_in;
			wb_latch_q <= wire_break_status_in;
			if (cs_fall) begin
				sts_latch_q <= sts_now;
			end
		end
	end
	// second byte: same-frame read in modes 0/1, held data in chain modes
	always_comb begin
		if (mode_q[1]) begin
			byte2 = prev_read_q ? read_hold_q : wb_latch_q;
		end else begin
			byte2 = wb_latch_q;
		end
	end
	// check bits follow payload, one shift register per direction
	assign crc_seed  = cs_fall;
	assign crc_shift = rise && (cnt_q < 6'(`IISF_PAYLOAD_BITS));
	assign crc_bit   = sdi;
	iisf_crc5 u_rx_crc (
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.seed_in  (crc_seed),
		.shift_in (crc_shift),
		.bit_in   (crc_bit),
		.crc_out  (crc_val)
	);
	// outgoing check bits follow the bits as the host samples them
	iisf_crc5 u_tx_crc (
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.seed_in  (crc_seed),
		.shift_in (crc_shift),
		.bit_in   (host_serial_out_out),
		.crc_out  (tx_crc_val)
	);
	// frame state and shifters
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_q <= IISF_IDLE;
			cnt_q   <= 6'h00;
			rx_q    <= 24'h000000;
			tx_q    <= 24'h000000;
		end else begin
			case (state_q)
				IISF_IDLE: begin
					if (cs_fall) begin
						state_q <= IISF_SHIFT;
						cnt_q   <= 6'h00;
						tx_q    <= {input_state_byte_in, 16'h0000};
					end
				end
				IISF_SHIFT: begin
					if (cs_n) begin
						state_q <= IISF_DONE;
					end else begin
						if (rise) begin
							rx_q  <= {rx_q[22:0], sdi};
							cnt_q <= cnt_q + 6'h01;
						end
						if (fall && cnt_q == 6'h01) begin
							tx_q <= {di_latch_q[6:0], byte2, sts_latch_q, 6'h00};
						end else if (fall && cnt_q == 6'h09 && !mode_q[1] && !rx_q[8]) begin
							tx_q <= {reg_read_data_in, 3'h0, sts_now, 10'h000};
						end else if (fall) begin
							tx_q <= {tx_q[22:0], 1'b0};
						end
					end
				end
				default: begin
					state_q <= IISF_IDLE;
				end
			endcase
		end
	end
	// the latch loads on the same edge, so the first bit is taken from the live byte
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			host_serial_out_out <= 1'b0;
		end else if (cs_fall) begin
			host_serial_out_out <= input_state_byte_in[7];
		end else if (fall && use_crc && cnt_q >= 6'(`IISF_PAYLOAD_BITS) && cnt_q < 6'(`IISF_FRAME_CRC)) begin
			host_serial_out_out <= tx_crc_val[3'(6'(`IISF_FRAME_CRC) - 6'h01 - cnt_q)];
		end else if (fall) begin
			host_serial_out_out <= tx_q[22];
		end
	end
	// frame accepted only if count is good and, in check modes 0/2, the check too
	always_comb begin
		frame_ok = 1'b1;
		if (use_crc) begin
			frame_ok = (cnt_q == 6'(`IISF_FRAME_CRC)) && (rx_q[4:0] == crc_val);
		end else begin
			frame_ok = (cnt_q == 6'(`IISF_FRAME_PLAIN));
		end
	end
	// register port: write only on a good frame, no-op writes nothing
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			reg_write_out         <= 1'b0;
			reg_addr_out          <= 5'h00;
			reg_write_data_out    <= 8'h00;
			clock_count_error_out <= 1'b0;
			crc_err_q             <= 1'b0;
			prev_read_q           <= 1'b0;
			read_hold_q           <= 8'h00;
			secondary_read_out    <= 1'b0;
		end else begin
			reg_write_out      <= 1'b0;
			secondary_read_out <= 1'b0;
			clock_count_error_out <= 1'b0;
			if (state_q == IISF_DONE) begin
				if (cnt_q[2:0] != 3'h0) begin
					clock_count_error_out <= 1'b1;
				end else if (use_crc && !frame_ok) begin
					crc_err_q <= 1'b1;
				end else if (frame_ok) begin
					crc_err_q    <= 1'b0;
					reg_addr_out <= use_crc ? rx_q[22:18] : rx_q[14:10];
					prev_read_q  <= use_crc ? ~rx_q[23] : ~rx_q[15];
					if (use_crc ? rx_q[23] : rx_q[15]) begin
						reg_write_data_out <= use_crc ? rx_q[15:8] : rx_q[7:0];
						reg_write_out      <= 1'b1;
					end else begin
						read_hold_q <= reg_read_data_in;
						if ((use_crc ? rx_q[22:18] : rx_q[14:10]) == `IISF_ADDR_FLT2) begin
							secondary_read_out <= 1'b1;
						end
					end
				end
			end
		end
	end
	// primary fault register; persistent conditions win over the clear
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			flt1_q <= `IISF_FLT1_RESET;
		end else begin
			if (reg_write_out && reg_addr_out == `IISF_ADDR_FLT1) begin
				flt1_q[`IISF_FLT1_POR] <= 1'b0;
			end
			if (secondary_read_out == 1'b0 && state_q == IISF_IDLE && prev_read_q && reg_addr_out == `IISF_ADDR_FLT1) begin
				flt1_q[`IISF_FLT1_SUPLOW] <= field_supply_low_in;
				flt1_q[`IISF_FLT1_SUPMIS] <= field_supply_missing_in | supply_loss_event_in;
			end else begin
				flt1_q[`IISF_FLT1_SUPLOW] <= flt1_q[`IISF_FLT1_SUPLOW] | field_supply_low_in;
				flt1_q[`IISF_FLT1_SUPMIS] <= flt1_q[`IISF_FLT1_SUPMIS] | field_supply_missing_in | supply_loss_event_in;
			end
			flt1_q[`IISF_FLT1_CRC] <= crc_err_q;
			flt1_q[`IISF_FLT1_WBG] <= wire_break_summary_in;
			flt1_q[`IISF_FLT1_F2]  <= secondary_fault_in;
		end
	end
	// fault pins kept active low in their flops; only check and power-on route by default
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			host_fault_out_n_n_q <= 1'b0;
			field_fault_out_n_n_q <= 1'b1;
			ready_q    <= 1'b0;
		end else begin
			ready_q    <= mode_ok_q;
			field_fault_out_n_n_q <= ~(crc_err_q & check_error_alert_enable_in);
			if (fault_latch_mode_in) begin
				host_fault_out_n_n_q <= host_fault_out_n_n_q & ~crc_err_q & ~flt1_q[`IISF_FLT1_POR];
				if (reg_write_out && reg_addr_out == `IISF_ADDR_FLT1) begin
					host_fault_out_n_n_q <= ~crc_err_q;
				end
			end else begin
				host_fault_out_n_n_q <= ~(crc_err_q | flt1_q[`IISF_FLT1_POR]);
			end
		end
	end
	assign host_fault_out_n_out  = host_fault_out_n_n_q;
	assign field_fault_out_n_out = field_fault_out_n_n_q;
	assign field_ready_ind_out   = ready_q;
	assign primary_fault_reg_out = flt1_q;
endmodule

// ===== iisf_host_model.sv
// host side spi master model for the frame engine, mode 0, one frame per call
// assumes clk_in is the bench clock; a link half period is 16 of its cycles
`timescale 1ns/1ps
module iisf_host_model (
	// bench clock
	input  wire logic clk_in,
	// spi pins
	input  wire logic miso_in,
	output logic      cs_n_out,
	output logic      sclk_out,
	output logic      mosi_out
);
	initial begin
		cs_n_out = 1'b1;
		sclk_out = 1'b0; // rests low outside frames; lone device, last in chain
		mosi_out = 1'b0;
	end
	task automatic half();
		repeat (16) @(posedge clk_in);
		#1;
	endtask
	task automatic frame(input logic [23:0] f, input int n, output logic [23:0] got);
		got = 24'h000000;
		cs_n_out = 1'b0;
		for (int i = 0; i < n; i++) begin
			mosi_out = f[23 - (i % 24)]; // msb first, changed with the fall
			half();
			sclk_out = 1'b1; // device samples on the rise
			if (i < 24)
				got[23 - i] = miso_in;
			half();
			sclk_out = 1'b0;
		end
		half();
		cs_n_out = 1'b1;
		mosi_out = ~mosi_out; // released line must not keep the last bit
		half();
	endtask
endmodule

// ===== iisf_frame_sva.sv
// port assertions for the frame engine
// assumes binding to every iisf_frame instance
`timescale 1ns/1ps
module iisf_frame_chk (
	input wire logic       clk_in,
	input wire logic       rst_in,
	input wire logic       host_chip_select_n_in,
	input wire logic       secondary_fault_in,
	input wire logic       supply_loss_event_in,
	input wire logic       check_error_alert_enable_in,
	input wire logic       host_fault_out_n_out,
	input wire logic       field_ready_ind_out,
	input wire logic       field_fault_out_n_out,
	input wire logic [4:0] reg_addr_out,
	input wire logic       reg_write_out,
	input wire logic       secondary_read_out,
	input wire logic       clock_count_error_out,
	input wire logic [7:0] primary_fault_reg_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	reset_val_a: assert property (
		$fell(rst_in) |-> primary_fault_reg_out == 8'h02 && !host_fault_out_n_out) else $error("bad reset state");
	ready_up_a: assert property (
		$fell(rst_in) |-> ##[0:4] field_ready_ind_out) else $error("ready late");
	write_pulse_a: assert property (
		reg_write_out |=> !reg_write_out) else $error("write pulse too long");
	write_after_a: assert property (
		reg_write_out |-> host_chip_select_n_in && $past(host_chip_select_n_in, 2)) else $error("write inside frame");
	count_err_a: assert property (
		clock_count_error_out |-> !reg_write_out [*8]) else $error("write after bad count");
	fault_pin_a: assert property (
		(primary_fault_reg_out[0] && check_error_alert_enable_in) [*2] |-> !field_fault_out_n_out) else $error("pin idle");
	fault_clr_a: assert property (
		(!primary_fault_reg_out[0]) [*2] |-> field_fault_out_n_out) else $error("pin stuck");
	loss_flag_a: assert property (
		supply_loss_event_in |=> primary_fault_reg_out[3]) else $error("loss not reported");
	flag_end_a: assert property (
		$changed(primary_fault_reg_out[0]) |-> host_chip_select_n_in) else $error("flag moved in frame");
	f2_mirror_a: assert property (
		secondary_fault_in [*4] |-> primary_fault_reg_out[5]) else $error("bit 5 missing");
	sec_read_a: assert property (
		secondary_read_out |-> reg_addr_out == 5'h1C && !reg_write_out) else $error("bad secondary read");
endmodule
bind iisf_frame iisf_frame_chk chk_u (.clk_in, .rst_in, .host_chip_select_n_in, .secondary_fault_in, .supply_loss_event_in,
	.check_error_alert_enable_in, .host_fault_out_n_out, .field_ready_ind_out, .field_fault_out_n_out,
	.reg_addr_out, .reg_write_out, .secondary_read_out, .clock_count_error_out, .primary_fault_reg_out);

// ===== tb_iisf_frame.sv
// self-checking bench for iisf_frame: strap modes, check bits, fault flags
// assumes the host model file and the bound checker are compiled first
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin failures++; $display("unexpected %s exp %0h got %0h", nm, e, a); end end
module tb_iisf_frame;
	logic       clk_in, rst_in, strap_h, strap_l, en, lat, f2, cs_n, sclk, mosi, miso, sup_loss;
	logic       host_fault_out_n_n, ready, field_fault_out_n_n, wr, sec, cce, unused_wr;
	logic [7:0] di, wb, rd, wdata, pfr, wr_d;
	logic [23:0] got;
	logic [4:0] addr, wr_a, ra;
	int         failures, n_checks, wr_n, sec_n, cce_n, seed, tn;
	iisf_frame dut_u (.clk_in(clk_in), .rst_in(rst_in), .host_chip_select_n_in(cs_n),
		.host_serial_clock_in(sclk), .host_serial_in_in(mosi), .shared_capture_n_in(1'b1),
		.host_serial_out_out(miso), .host_fault_out_n_out(host_fault_out_n_n), .mode_strap_high_in(strap_h),
		.mode_strap_low_in(strap_l), .input_state_byte_in(di), .wire_break_status_in(wb),
		.field_supply_low_in(1'b0), .field_supply_missing_in(1'b0), .wire_break_summary_in(1'b0),
		.secondary_fault_in(f2), .supply_loss_event_in(sup_loss), .check_error_alert_enable_in(en),
		.fault_latch_mode_in(lat), .reg_read_data_in(rd), .field_ready_ind_out(ready),
		.field_fault_out_n_out(field_fault_out_n_n), .reg_addr_out(addr), .reg_write_data_out(wdata),
		.reg_write_out(wr), .secondary_read_out(sec), .clock_count_error_out(cce),
		.primary_fault_reg_out(pfr));
	iisf_host_model host_u (.clk_in(clk_in), .miso_in(miso), .cs_n_out(cs_n), .sclk_out(sclk), .mosi_out(mosi));
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		if (wr === 1'b1) begin
			wr_n++;
			wr_a = addr;
			wr_d = wdata;
		end
		if (sec === 1'b1)
			sec_n++;
		if (cce === 1'b1)
			cce_n++;
	end
	function automatic logic [4:0] crc5(input logic [23:0] f);
		logic [4:0] c;
		logic       b;
		c = 5'h07; // seeded 00111, 19 bits
		for (int i = 23; i >= 5; i--) begin
			b = c[4] ^ f[i];
			c = {c[3:0], 1'b0} ^ (b ? 5'h15 : 5'h00); // msb first shift register
		end
		return c;
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic do_reset(input logic [1:0] m);
		rst_in = 1'b1;
		{strap_h, strap_l} = m;
		tick(6);
		rst_in = 1'b0;
		tick(1);
		`CHK("fault reg", 8'h02, pfr)
		`CHK("host fault", 1'b0, host_fault_out_n_n)
		for (int i = 0; i < 20 && ready !== 1'b1; i++)
			tick(1);
		`CHK("ready", 1'b1, ready)
	endtask
	task automatic send(input logic rw, input logic [4:0] a, input logic [7:0] d, input logic bad, input int n);
		logic [23:0] f;
		int          w0;
		f = {rw, a, 2'b00, d, 3'b000, 5'h00};
		f[4:0] = crc5(f) ^ {4'h0, bad}; // check bits end the frame
		if (n < 24)
			f = {f[23:8], 8'h00};
		w0 = wr_n;
		di = 8'($random(seed));
		wb = 8'($random(seed));
		rd = 8'($random(seed));
		host_u.frame(f, n, got);
		tick(20);
		`CHK("first byte", di, got[23:16])
		if (rw)
			`CHK("second byte", wb, got[15:8])
		if (!strap_l && n == 24)
			`CHK("device crc", crc5(got), got[4:0])
		`CHK("writes", w0 + ((rw && !bad && n % 8 == 0) ? 1 : 0), wr_n)
		if (wr_n != w0) begin
			`CHK("addr", a, wr_a)
			`CHK("data", d, wr_d)
		end
		tn++;
		$display("test %0d done", tn);
	endtask
	initial begin
		seed = 32'h6674;
		{rst_in, strap_h, strap_l, en, lat, f2, sup_loss, di, wb, rd} = '0;
		{failures, n_checks, wr_n, sec_n, cce_n, tn} = '0;
		for (int m = 0; m < 4; m++) begin
			do_reset(m[1:0]);
			ra = 5'($random(seed)) & 5'h1B;
			send(1'b1, ra, 8'($random(seed)), 1'b0, m[0] ? 16 : 24);
		end
		do_reset(2'b00);
		en = 1'b1;
		send(1'b1, 5'h03, 8'hA5, 1'b1, 24);
		`CHK("check flag", 1'b1, pfr[0])
		`CHK("field fault", 1'b0, field_fault_out_n_n)
		send(1'b1, 5'h03, 8'h5A, 1'b0, 24);
		`CHK("check flag", 1'b0, pfr[0])
		`CHK("field fault", 1'b1, field_fault_out_n_n)
		send(1'b1, 5'h03, 8'h5A, 1'b0, 20);
		`CHK("count err", 1, cce_n)
		send(1'b0, 5'h1C, 8'h00, 1'b0, 24);
		`CHK("sec read", 1, sec_n)
		send(1'b1, 5'h04, 8'h00, 1'b0, 24);
		`CHK("power flag", 1'b0, pfr[1])
		for (int i = 0; i < 4; i++) begin
			en = 1'($random(seed));
			lat = 1'($random(seed));
			send(1'b1, 5'($random(seed)) & 5'h1B, 8'($random(seed)), 1'b0, 24);
		end
		sup_loss = 1'b1;
		tick(1);
		sup_loss = 1'b0;
		tick(4);
		`CHK("supply loss", 1'b1, pfr[3])
		f2 = 1'b1;
		tick(8);
		`CHK("bit 5", 1'b1, pfr[5])
		tally_and_finish();
	end
	initial begin
		// about four times the length of the planned frames
		#200000;
		failures++;
		tally_and_finish();
	end
endmodule
